// ---- src/ras_stack.sv ----
`timescale 1ns/1ps
// Contract
// - Stack holds sixteen entries of fifteen bits each.
// - Stack storage lives outside program and data memory spaces.
// - Calls, call_via_wreg and interrupt vectoring push the program counter.
// - Return, return_with_literal and return_from_interrupt pop into the PC.
// - Push and pop never touch pc_latch_high.
// - With overflow reset disabled the stack wraps as a circular buffer.
// - Seventeenth push overwrites the first entry, eighteenth the second.
// - Overflow and underflow flags set whether or not reset is enabled.
// - Pointer selects the entry seen through top_entry_high and top_entry_low.
// - Top entry shows as separate readable, writable high and low bytes.
// - Stack pointer is five bits so faults can be detected.
// - Push increments the pointer, then writes the PC there.
// - Pop reads the addressed entry, then decrements the pointer.
// - Pointer addresses the last pushed entry not yet popped, unless software writes the pointer.
module ras_stack
   import ras_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic overflow_reset_enable,
   input wire logic push_req,
   input wire logic pop_req,
   input wire logic [14:0] push_pc,
   output logic [14:0] pop_pc_q,
   output logic pop_valid_q,
   output logic fault_reset_q,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata_q,
   output logic irq_q
);

   logic [RAS_PC_W-1:0] entry_q [RAS_DEPTH];
   logic [RAS_PTR_W-1:0] ptr_q;
   logic [RAS_PTR_W-1:0] ptr_d;
   logic [RAS_IRQ_W-1:0] mask_q;
   logic [RAS_IRQ_W-1:0] status;
   logic [RAS_IRQ_W-1:0] status_set;
   logic status_clear;
   logic ovf_flag_q;
   logic unf_flag_q;
   logic cause_clear_ovf;
   logic cause_clear_unf;
   ras_op_type op;
   logic [3:0] slot;
   logic [3:0] push_slot;
   logic overflow;
   logic underflow;
   logic do_push;
   logic do_pop;
   logic wr_ptr;
   logic wr_lo;
   logic wr_hi;
   logic [7:0] rdata_d;
   logic [RAS_IRQ_W-1:0] status_next;
   logic [RAS_IRQ_W-1:0] mask_next;
   logic wr_cause;
   logic wr_mask;
   logic fault_hit;
   logic [3:0] fault_cnt_q;

   // Pop wins if the sequencer ever raises both, a return never overlaps a call
   always_comb
   begin
      if (pop_req)
      begin
         op = RAS_OP_POP;
      end
      else if (push_req)
      begin
         op = RAS_OP_PUSH;
      end
      else
      begin
         op = RAS_OP_NONE;
      end
   end

   assign wr_ptr = reg_write && (reg_addr == RAS_OFF_PTR);
   assign wr_lo = reg_write && (reg_addr == RAS_OFF_TOP_LO);
   assign wr_hi = reg_write && (reg_addr == RAS_OFF_TOP_HI);
   assign wr_cause = reg_write && (reg_addr == RAS_OFF_CAUSE);
   assign wr_mask = reg_write && (reg_addr == RAS_OFF_MASK);

   // Full stack sits at index 15; empty at the all-ones pointer
   assign overflow = (op == RAS_OP_PUSH) && (ptr_q == 5'h0F);
   assign underflow = (op == RAS_OP_POP) && (ptr_q == 5'h1F);
   // Enabled fault reset refuses the request; circular mode lets it through
   assign do_push = (op == RAS_OP_PUSH) && !(overflow && overflow_reset_enable);
   assign do_pop = (op == RAS_OP_POP) && !(underflow && overflow_reset_enable);

   assign slot = ptr_q[3:0];
   assign push_slot = 4'(ptr_q + 5'h01);

   // Pointer: core operations beat a software write in the same cycle
   always_comb
   begin
      ptr_d = ptr_q;
      if (do_push)
      begin
         // Wraps inside four bits when reset is off, so depth stays sixteen
         ptr_d = {1'b0, push_slot};
      end
      else if (do_pop)
      begin
         ptr_d = ptr_q - 5'h01;
      end
      else if (wr_ptr)
      begin
         ptr_d = reg_wdata[RAS_PTR_W-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         // Empty sits one below entry zero, so the first push lands there
         ptr_q <= RAS_PTR_RESET;
      end
      else
      begin
         ptr_q <= ptr_d;
      end
   end

   // Private array, not decoded from any memory address
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < RAS_DEPTH; i++)
         begin
            entry_q[i] <= RAS_ENTRY_RESET;
         end
      end
      else if (do_push)
      begin
         entry_q[push_slot] <= push_pc;
      end
      // A byte write in a push cycle is lost; the push wins
      else if (wr_lo)
      begin
         entry_q[slot][7:0] <= reg_wdata;
      end
      else if (wr_hi)
      begin
         entry_q[slot][14:8] <= reg_wdata[6:0];
      end
   end

   // Return address comes out of the entry before the pointer moves
   // Holds until the next accepted pop, so a late reader still sees it
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pop_pc_q <= RAS_ENTRY_RESET;
      end
      else if (do_pop)
      begin
         pop_pc_q <= entry_q[slot];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pop_valid_q <= 1'b0;
      end
      else
      begin
         pop_valid_q <= do_pop;
      end
   end

   // Only stack state changes here; the PC latch register is not a port

   // Fault asks for a reset only while the reset option is on
   assign fault_hit = (overflow || underflow) && overflow_reset_enable;

   // Pulse length is a package count so a slow system reset can be met
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         fault_cnt_q <= 4'h0;
      end
      else if (fault_hit)
      begin
         fault_cnt_q <= 4'(RAS_FAULT_RST_CYC - 1);
      end
      else if (fault_cnt_q != 4'h0)
      begin
         fault_cnt_q <= fault_cnt_q - 4'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         fault_reset_q <= 1'b0;
      end
      else
      begin
         fault_reset_q <= fault_hit || (fault_cnt_q != 4'h0);
      end
   end

   // Cause flags are cleared by writing zero; the reset input clears them too,
   // so the fault pulse must not be looped back onto it
   assign cause_clear_ovf = wr_cause && !reg_wdata[RAS_CAUSE_OVF_BIT];
   assign cause_clear_unf = wr_cause && !reg_wdata[RAS_CAUSE_UNF_BIT];

   // Set wins over a clearing write in the same cycle
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ovf_flag_q <= 1'b0;
      end
      else if (overflow)
      begin
         ovf_flag_q <= 1'b1;
      end
      else if (cause_clear_ovf)
      begin
         ovf_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         unf_flag_q <= 1'b0;
      end
      else if (underflow)
      begin
         unf_flag_q <= 1'b1;
      end
      else if (cause_clear_unf)
      begin
         unf_flag_q <= 1'b0;
      end
   end

   // Interrupt status: push, pop, overflow, underflow events
   assign status_set[RAS_IRQ_PUSH_BIT] = do_push;
   assign status_set[RAS_IRQ_POP_BIT] = do_pop;
   assign status_set[RAS_IRQ_OVF_BIT] = overflow;
   assign status_set[RAS_IRQ_UNF_BIT] = underflow;
   assign status_clear = reg_read && (reg_addr == RAS_OFF_STATUS);

   // Next status and mask, so irq_q never lags them by a cycle
   assign status_next = status_set | (status & ~{RAS_IRQ_W{status_clear}});
   assign mask_next = wr_mask ? reg_wdata[RAS_IRQ_W-1:0] : mask_q;

   // One sticky cell per event; one status read clears them all
   genvar g;
   generate
      for (g = 0; g < RAS_IRQ_W; g++)
      begin : g_sticky
         ras_sticky u_sticky
         (
            .clk(clk),
            .reset(reset),
            .set(status_set[g]),
            .clear(status_clear),
            .flag_q(status[g])
         );
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         mask_q <= RAS_MASK_RESET;
      end
      else if (wr_mask)
      begin
         mask_q <= reg_wdata[RAS_IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= |(status_next & mask_next);
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rdata_d = 8'h00;
      case (reg_addr)
         RAS_OFF_CAUSE:
         begin
            rdata_d[RAS_CAUSE_OVF_BIT] = ovf_flag_q;
            rdata_d[RAS_CAUSE_UNF_BIT] = unf_flag_q;
         end
         RAS_OFF_PTR: rdata_d = {3'h0, ptr_q};
         RAS_OFF_TOP_LO: rdata_d = entry_q[slot][7:0];
         RAS_OFF_TOP_HI: rdata_d = {1'b0, entry_q[slot][14:8]};
         RAS_OFF_STATUS: rdata_d = {4'h0, status};
         RAS_OFF_MASK: rdata_d = {4'h0, mask_q};
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         reg_rdata_q <= 8'h00;
      end
      else if (reg_read)
      begin
         reg_rdata_q <= rdata_d;
      end
      else
      begin
         // Idle zero lets several register slaves share one OR-ed read bus
         reg_rdata_q <= 8'h00;
      end
   end

endmodule

// ---- src/ras_pkg.sv ----
package ras_pkg;

   localparam int RAS_DEPTH = 16;
   localparam int RAS_PC_W = 15;
   localparam int RAS_PTR_W = 5;

   // Register offsets on the core register port
   localparam logic [7:0] RAS_OFF_CAUSE = 8'h96;
   localparam logic [7:0] RAS_OFF_PTR = 8'hE0;
   localparam logic [7:0] RAS_OFF_TOP_LO = 8'hE1;
   localparam logic [7:0] RAS_OFF_TOP_HI = 8'hE2;
   localparam logic [7:0] RAS_OFF_STATUS = 8'hE3;
   localparam logic [7:0] RAS_OFF_MASK = 8'hE4;

   // Cause register fields
   localparam int RAS_CAUSE_OVF_BIT = 7;
   localparam int RAS_CAUSE_UNF_BIT = 6;

   // Interrupt status fields
   localparam int RAS_IRQ_PUSH_BIT = 0;
   localparam int RAS_IRQ_POP_BIT = 1;
   localparam int RAS_IRQ_OVF_BIT = 2;
   localparam int RAS_IRQ_UNF_BIT = 3;
   localparam int RAS_IRQ_W = 4;

   // Reset values
   localparam logic [4:0] RAS_PTR_RESET = 5'h1F;
   localparam logic [3:0] RAS_MASK_RESET = 4'h0;
   localparam logic [14:0] RAS_ENTRY_RESET = 15'h0000;

   // Length of the reset request pulse raised on a stack fault
   localparam int RAS_FAULT_RST_CYC = 1;

   typedef enum logic [1:0]
   {
      RAS_OP_NONE = 2'b00,
      RAS_OP_PUSH = 2'b01,
      RAS_OP_POP = 2'b10
   } ras_op_type;

endpackage

// ---- src/ras_sticky.sv ----
`timescale 1ns/1ps
module ras_sticky
   import ras_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic set,
   input wire logic clear,
   output logic flag_q
);

   // Set beats clear so an event in the clearing cycle survives
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         flag_q <= 1'b0;
      end
      else if (set)
      begin
         flag_q <= 1'b1;
      end
      else if (clear)
      begin
         flag_q <= 1'b0;
      end
   end

endmodule

// ---- test/ras_stack_sva.sv ----
`timescale 1ns/1ps
module ras_chk
   import ras_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic overflow_reset_enable,
   input wire logic push_req,
   input wire logic pop_req,
   input wire logic [14:0] pop_pc_q,
   input wire logic pop_valid_q,
   input wire logic fault_reset_q,
   input wire logic [7:0] reg_addr,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   AST_PV: assert property (pop_valid_q |-> $past(pop_req))
      else $error("pop answer without a return");
   AST_NOPOP: assert property (push_req && !pop_req |=> !pop_valid_q)
      else $error("push gave a pop answer");
   AST_FR: assert property (fault_reset_q |->
      $past(overflow_reset_enable && (push_req || pop_req)))
      else $error("fault reset without enabled fault");
   AST_FRNP: assert property (fault_reset_q |-> !pop_valid_q)
      else $error("refused pop still answered");
   AST_CIRC: assert property (!overflow_reset_enable |=> !fault_reset_q)
      else $error("fault reset while circular");
   AST_RD: assert property (!$past(reg_read) |-> reg_rdata_q == 8'h00)
      else $error("read data outside its cycle");
   AST_HI: assert property ($past(reg_read && reg_addr == RAS_OFF_TOP_HI)
      |-> !reg_rdata_q[7])
      else $error("high byte bit 7 set");
   AST_HOLD: assert property (!pop_valid_q |-> $stable(pop_pc_q))
      else $error("return address moved without pop");
endmodule

// ---- test/ras_core_model.sv ----
`timescale 1ns/1ps
module ras_core_model
(
   output logic push_req,
   output logic pop_req,
   output logic [14:0] push_pc,
   input wire logic clk
);
   initial
   begin
      push_req = 1'b0;
      pop_req = 1'b0;
      push_pc = 15'h0000;
   end
   // Leading edge wait keeps calls one cycle apart
   task call_op(input logic [14:0] pc);
      @(posedge clk);
      push_req <= 1'b1;
      push_pc <= pc;
      @(posedge clk);
      push_req <= 1'b0;
      push_pc <= ~pc;
   endtask
   task ret_op;
      @(posedge clk);
      pop_req <= 1'b1;
      @(posedge clk);
      pop_req <= 1'b0;
   endtask
endmodule

// ---- test/ras_stack_tb_top.sv ----
`timescale 1ns/1ps
module ras_stack_tb_top
   import ras_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic en = 1'b0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic push_req, pop_req, pop_valid_q, fault_reset_q, irq_q;
   logic [14:0] push_pc, pop_pc_q;
   logic [7:0] reg_rdata_q;
   int miscompares = 0;
   int checked = 0;
   always #50 clk = ~clk;
   ras_core_model cpu_u (.clk, .push_req, .pop_req, .push_pc);
   ras_stack dut_u (.clk, .reset, .overflow_reset_enable(en), .push_req, .pop_req,
      .push_pc, .pop_pc_q, .pop_valid_q, .fault_reset_q, .reg_addr, .reg_wdata,
      .reg_write, .reg_read, .reg_rdata_q, .irq_q);
   task cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task rst(input logic e);
      @(posedge clk);
      en <= e;
      reset <= 1'b1;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      cmp({8'h00, reg_rdata_q}, e);
   endtask
   task popc(input logic [14:0] e);
      cpu_u.ret_op;
      #1;
      cmp({15'h0000, pop_valid_q}, 16'h0001);
      cmp({1'b0, pop_pc_q}, {1'b0, e});
   endtask
   task chk_irq(input logic e);
      #1;
      cmp({15'h0000, irq_q}, {15'h0000, e});
   endtask
   task chk_fault(input logic e);
      #1;
      cmp({15'h0000, fault_reset_q}, {15'h0000, e});
   endtask
   task s_lifo;
      rdc(RAS_OFF_PTR, 16'h001F);
      rdc(RAS_OFF_MASK, 16'h0000);
      rdc(8'h10, 16'h0000);
      wr(RAS_OFF_MASK, 8'h0F);
      cpu_u.call_op(15'h1234);
      cpu_u.call_op(15'h7ABC);
      rdc(RAS_OFF_PTR, 16'h0001);
      rdc(RAS_OFF_TOP_LO, 16'h00BC);
      rdc(RAS_OFF_TOP_HI, 16'h007A);
      chk_irq(1'b1);
      rdc(RAS_OFF_STATUS, 16'h0001);
      chk_irq(1'b0);
      wr(RAS_OFF_MASK, 8'h02);
      cpu_u.call_op(15'h0055);
      chk_irq(1'b0);
      popc(15'h0055);
      chk_irq(1'b1);
      rdc(RAS_OFF_STATUS, 16'h0003);
      popc(15'h7ABC);
      popc(15'h1234);
      rdc(RAS_OFF_PTR, 16'h001F);
   endtask
   task s_window;
      // Pointer moved only while no call or return runs
      wr(RAS_OFF_PTR, 8'h00);
      wr(RAS_OFF_TOP_LO, 8'h5A);
      wr(RAS_OFF_TOP_HI, 8'h01);
      popc(15'h015A);
   endtask
   task s_circ;
      for (int i = 0; i < 17; i++) cpu_u.call_op(15'h0100 + 15'(i));
      rdc(RAS_OFF_PTR, 16'h0000);
      rdc(RAS_OFF_TOP_LO, 16'h0010);
      popc(15'h0110);
      cpu_u.ret_op;
      chk_fault(1'b0);
      rdc(RAS_OFF_CAUSE, 16'h00C0);
      rdc(RAS_OFF_PTR, 16'h001E);
      wr(RAS_OFF_CAUSE, 8'h00);
      rdc(RAS_OFF_CAUSE, 16'h0000);
   endtask
   task s_fault;
      rst(1'b1);
      for (int i = 0; i < 16; i++) cpu_u.call_op(15'(i));
      cpu_u.call_op(15'h7FFF);
      chk_fault(1'b1);
      rdc(RAS_OFF_PTR, 16'h000F);
      rdc(RAS_OFF_TOP_LO, 16'h000F);
      rdc(RAS_OFF_CAUSE, 16'h0080);
      rdc(RAS_OFF_STATUS, 16'h0005);
      rst(1'b1);
      cpu_u.ret_op;
      chk_fault(1'b1);
      rdc(RAS_OFF_CAUSE, 16'h0040);
      rdc(RAS_OFF_PTR, 16'h001F);
   endtask
   task print_verdict;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      rst(1'b0);
      s_lifo;
      s_window;
      s_circ;
      s_fault;
      print_verdict;
   end
endmodule
bind ras_stack ras_chk chk_u (.clk, .reset, .overflow_reset_enable, .push_req, .pop_req,
   .pop_pc_q, .pop_valid_q, .fault_reset_q, .reg_addr, .reg_read, .reg_rdata_q);
